//--- verilog/cmpsel_pkg.sv
package cmpsel_pkg;

    // ****************************************************************
    // register map (byte addresses, one aligned word per register)
    // ****************************************************************
    localparam logic [7:0] CMPSEL_ADDR_MUX = 8'h00;     // conv_mux_reg
    localparam logic [7:0] CMPSEL_ADDR_CTRL_A = 8'h04;  // conv_ctrl_a_reg
    localparam logic [7:0] CMPSEL_ADDR_CTRL_B = 8'h08;  // conv_ctrl_b_reg
    localparam logic [7:0] CMPSEL_ADDR_CSR = 8'h0c;     // cmp_ctrl_status_reg
    localparam logic [7:0] CMPSEL_ADDR_PIN_DIS = 8'h10; // digital input disable
    localparam logic [7:0] CMPSEL_ADDR_STATUS = 8'h14;  // routing status, read only
    localparam logic [7:0] CMPSEL_ADDR_PIN = 8'h18;     // port input view, read only

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CMPSEL_MUX_SEL_LSB = 0;      // conv_channel_select [4:0]
    localparam int CMPSEL_MUX_REF_SEL_LSB = 6;  // conv_ref_select [7:6]
    localparam int CMPSEL_CTRL_A_EN_BIT = 7;    // conv_enable
    localparam int CMPSEL_CTRL_B_ME_BIT = 6;    // cmp_mux_enable
    localparam int CMPSEL_CTRL_B_DIV_LSB = 4;   // ref_division_select [5:4]
    localparam int CMPSEL_CSR_IRS_BIT = 6;      // cmp_internal_ref_select
    localparam int CMPSEL_PIN_DIS_POS_BIT = 7;  // pos_pin_input_disable
    localparam int CMPSEL_PIN_DIS_NEG_BIT = 6;  // neg_pin_input_disable

    // ****************************************************************
    // encodings and reset values
    // ****************************************************************
    localparam logic [4:0] CMPSEL_CHAN_MAX = 5'h0a;     // highest defined channel
    localparam logic [1:0] CMPSEL_REF_SEL_INTERNAL = 2'h3; // internal 2.56 V reference
    localparam logic [7:0] CMPSEL_REG_RESET = 8'h00;
    localparam int CMPSEL_NUM_CHAN = 11;

    // negative input source
    typedef enum logic [1:0] {
        CMPSEL_NEG_PIN = 2'b00,
        CMPSEL_NEG_DAC = 2'b01,
        CMPSEL_NEG_RSVD = 2'b10
    } cmpsel_neg_src_t;

    // positive input route
    typedef struct packed {
        logic use_mux;
        logic [4:0] channel;
        logic channel_valid;
    } cmpsel_pos_route_t;

    // negative input route, div is the reference shift (0 full .. 3 eighth)
    typedef struct packed {
        cmpsel_neg_src_t src;
        logic [1:0] div;
    } cmpsel_neg_route_t;

endpackage : cmpsel_pkg

//--- verilog/cmpsel_pos_route.sv
`timescale 1ns/1ps
module cmpsel_pos_route #(
    parameter int NUM_CHAN = 11
) (
    input wire logic mux_enable,
    input wire logic conv_enable,
    input wire logic [4:0] channel_select,
    output cmpsel_pkg::cmpsel_pos_route_t next_route,
    output logic [NUM_CHAN-1:0] next_chan_onehot
);
    import cmpsel_pkg::*;

    // ****************************************************************
    // positive input selection
    // ****************************************************************
    wire use_mux = mux_enable & ~conv_enable;
    wire chan_ok = (channel_select <= CMPSEL_CHAN_MAX);

    // out-of-range codes leave every channel switch open, not a random pin
    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_chan
            assign next_chan_onehot[g] = use_mux & (channel_select == 5'(g));
        end
    endgenerate

    assign next_route.use_mux = use_mux;
    assign next_route.channel = channel_select;
    assign next_route.channel_valid = use_mux & chan_ok;
endmodule : cmpsel_pos_route

//--- verilog/cmpsel_neg_route.sv
`timescale 1ns/1ps
module cmpsel_neg_route (
    input wire logic internal_ref_select,
    input wire logic [1:0] ref_division,
    input wire logic [1:0] conv_ref_select,
    output cmpsel_pkg::cmpsel_neg_route_t next_route
);
    import cmpsel_pkg::*;

    // ****************************************************************
    // negative input selection
    // ****************************************************************
    // reserved reference settings are flagged so the dac stays parked
    wire ref_ok = (conv_ref_select == CMPSEL_REF_SEL_INTERNAL);
    assign next_route.src = !internal_ref_select ? CMPSEL_NEG_PIN :
                            (ref_ok ? CMPSEL_NEG_DAC : CMPSEL_NEG_RSVD);
    assign next_route.div = ref_division;
endmodule : cmpsel_neg_route

//--- verilog/cmpsel_top.sv
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// - setting a pin's disable bit turns off that pin's digital input buffer.
// - while a pin's disable bit is set, its port input bit reads zero.
// - mux enable set, converter off: selected channel feeds the positive input.
// - mux enable clear or converter on: positive pin feeds the positive input.
// - channel codes 0 to 10 pick channels 0 to 10; code 3 shares current source.
// - reference select set uses divided internal reference only with conv_ref_select 11, else neither; clear uses negative pin.
// - division codes 00..11 give full, half, quarter, eighth of 2.56 V.
module cmpsel_top #(
    parameter int NUM_CHAN = 11
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // raw digital levels of the two comparator pins
    input wire logic cmp_pos_pin_raw,
    input wire logic cmp_neg_pin_raw,
    // analog switch controls
    output logic cmp_pos_buf_enable,
    output logic cmp_neg_buf_enable,
    output logic pos_sel_pin,
    output logic [NUM_CHAN-1:0] pos_sel_chan,
    output logic neg_sel_pin,
    output logic neg_sel_dac,
    output logic [1:0] dac_division,
    output logic conv_enable
);
    import cmpsel_pkg::*;

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic [7:0] conv_mux_reg;
    logic [7:0] conv_ctrl_a_reg;
    logic [7:0] conv_ctrl_b_reg;
    logic [7:0] cmp_ctrl_status_reg;
    logic [7:0] pin_disable_reg;

    wire [4:0] conv_channel_select = conv_mux_reg[CMPSEL_MUX_SEL_LSB +: 5];
    wire [1:0] conv_ref_select = conv_mux_reg[CMPSEL_MUX_REF_SEL_LSB +: 2];
    wire conv_en_bit = conv_ctrl_a_reg[CMPSEL_CTRL_A_EN_BIT];
    wire cmp_mux_enable = conv_ctrl_b_reg[CMPSEL_CTRL_B_ME_BIT];
    wire [1:0] ref_division_select = conv_ctrl_b_reg[CMPSEL_CTRL_B_DIV_LSB +: 2];
    wire cmp_internal_ref_select = cmp_ctrl_status_reg[CMPSEL_CSR_IRS_BIT];
    wire pos_pin_input_disable = pin_disable_reg[CMPSEL_PIN_DIS_POS_BIT];
    wire neg_pin_input_disable = pin_disable_reg[CMPSEL_PIN_DIS_NEG_BIT];

    // ****************************************************************
    // axi4-lite write path
    // ****************************************************************
    // address and data are latched independently so either may come first
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire aw_have = aw_held | aw_take;
    wire w_have = w_held | w_take;
    wire do_write = aw_have & w_have;
    wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [7:0] wr_data = w_held ? w_data : s_axi_wdata[7:0];
    wire wr_lane0 = w_held ? w_lane0 : s_axi_wstrb[0];

    // decode used by both the write and the read path
    function automatic logic [2:0] cmpsel_decode(input logic [7:0] addr);
        unique case (addr)
            CMPSEL_ADDR_MUX: cmpsel_decode = 3'h1;
            CMPSEL_ADDR_CTRL_A: cmpsel_decode = 3'h2;
            CMPSEL_ADDR_CTRL_B: cmpsel_decode = 3'h3;
            CMPSEL_ADDR_CSR: cmpsel_decode = 3'h4;
            CMPSEL_ADDR_PIN_DIS: cmpsel_decode = 3'h5;
            CMPSEL_ADDR_STATUS: cmpsel_decode = 3'h6;
            CMPSEL_ADDR_PIN: cmpsel_decode = 3'h7;
            default: cmpsel_decode = 3'h0;
        endcase
    endfunction : cmpsel_decode

    wire [2:0] wr_sel = cmpsel_decode(wr_addr);
    wire wr_ok = (wr_sel != 3'h0);
    wire wr_en = do_write & wr_lane0;

    // handshake bookkeeping
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
        end else begin
            aw_held <= aw_have & ~do_write;
            w_held <= w_have & ~do_write;
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
        end
    end

    // write response, slverr for unmapped addresses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // register updates, visible to the routing as soon as the flops load
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_mux_reg <= CMPSEL_REG_RESET;
            conv_ctrl_a_reg <= CMPSEL_REG_RESET;
            conv_ctrl_b_reg <= CMPSEL_REG_RESET;
            cmp_ctrl_status_reg <= CMPSEL_REG_RESET;
            pin_disable_reg <= CMPSEL_REG_RESET;
        end else if (wr_en) begin
            if (wr_sel == 3'h1) conv_mux_reg <= wr_data & 8'hdf;
            if (wr_sel == 3'h2) conv_ctrl_a_reg <= wr_data;
            if (wr_sel == 3'h3) conv_ctrl_b_reg <= wr_data & 8'h77;
            if (wr_sel == 3'h4) cmp_ctrl_status_reg <= wr_data;
            if (wr_sel == 3'h5) pin_disable_reg <= wr_data;
        end
    end

    // ****************************************************************
    // routing
    // ****************************************************************
    cmpsel_pos_route_t next_pos;
    cmpsel_neg_route_t next_neg;
    logic [NUM_CHAN-1:0] next_onehot;

    cmpsel_pos_route #(
        .NUM_CHAN(NUM_CHAN)
    ) u_pos (
        .mux_enable(cmp_mux_enable),
        .conv_enable(conv_en_bit),
        .channel_select(conv_channel_select),
        .next_route(next_pos),
        .next_chan_onehot(next_onehot)
    );

    cmpsel_neg_route u_neg (
        .internal_ref_select(cmp_internal_ref_select),
        .ref_division(ref_division_select),
        .conv_ref_select(conv_ref_select),
        .next_route(next_neg)
    );

    // switch controls decode straight from the control flops, so a write lands
    // next cycle; between writes the flops hold them steady for the analog side
    assign pos_sel_pin = ~next_pos.use_mux;
    assign pos_sel_chan = next_onehot;
    assign neg_sel_pin = (next_neg.src == CMPSEL_NEG_PIN);
    assign neg_sel_dac = (next_neg.src == CMPSEL_NEG_DAC);
    assign dac_division = next_neg.div;
    assign conv_enable = conv_en_bit;
    assign cmp_pos_buf_enable = ~pos_pin_input_disable;
    assign cmp_neg_buf_enable = ~neg_pin_input_disable;

    // port input view forced to zero while the buffer is off
    wire pos_pin_read = cmp_pos_pin_raw & ~pos_pin_input_disable;
    wire neg_pin_read = cmp_neg_pin_raw & ~neg_pin_input_disable;

    // ****************************************************************
    // axi4-lite read path
    // ****************************************************************
    assign s_axi_arready = ~s_axi_rvalid;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire [2:0] rd_sel = cmpsel_decode(s_axi_araddr);
    wire [7:0] status_view = {next_neg.src, next_neg.div, next_pos.channel_valid,
                              next_pos.use_mux, 2'b00};

    logic [7:0] rd_byte;
    always_comb begin
        unique case (rd_sel)
            3'h1: rd_byte = conv_mux_reg;
            3'h2: rd_byte = conv_ctrl_a_reg;
            3'h3: rd_byte = conv_ctrl_b_reg;
            3'h4: rd_byte = cmp_ctrl_status_reg;
            3'h5: rd_byte = pin_disable_reg;
            3'h6: rd_byte = status_view;
            3'h7: rd_byte = {6'h00, pos_pin_read, neg_pin_read};
            default: rd_byte = 8'h00;
        endcase
    end

    // read data registered; unmapped answers slverr with zero data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= (rd_sel != 3'h0) ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : cmpsel_top

//--- sim/cmpsel_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// routing and bus handshake checker
// ****************************************************************
module cmpsel_sva #(
    parameter int NUM_CHAN = 11
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pos_sel_pin,
    input wire logic [NUM_CHAN-1:0] pos_sel_chan,
    input wire logic neg_sel_pin,
    input wire logic neg_sel_dac,
    input wire logic conv_enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // a handshake completes when valid meets ready at one edge
    sequence rd_done_s;
        s_axi_rvalid && s_axi_rready;
    endsequence
    sequence wr_done_s;
        s_axi_bvalid && s_axi_bready;
    endsequence
    pin_chan_excl_a: assert property (pos_sel_pin |-> pos_sel_chan == '0)
        else $error("positive pin and a channel routed together");
    chan_onehot_a: assert property ($onehot0(pos_sel_chan))
        else $error("more than one channel switch closed");
    conv_on_pin_a: assert property (conv_enable |-> pos_sel_pin)
        else $error("converter on but positive pin not routed");
    chan_conv_off_a: assert property (|pos_sel_chan |-> !conv_enable && !pos_sel_pin)
        else $error("channel routed while converter on");
    neg_src_excl_a: assert property (!(neg_sel_pin && neg_sel_dac))
        else $error("both negative sources routed");
    // routing may only move at the edge that raises the write response
    route_on_write_a: assert property ($changed({pos_sel_pin, pos_sel_chan, neg_sel_dac})
        |-> $rose(s_axi_bvalid))
        else $error("routing changed without a write");
    arready_rule_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready while a read is pending");
    read_once_a: assert property (rd_done_s |=> !s_axi_rvalid)
        else $error("read answer repeated");
    write_once_a: assert property (wr_done_s |=> !s_axi_bvalid)
        else $error("write answer repeated");
endmodule : cmpsel_sva

bind cmpsel_top cmpsel_sva #(.NUM_CHAN(NUM_CHAN)) u_sva (.aclk, .aresetn, .s_axi_arready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .pos_sel_pin, .pos_sel_chan,
    .neg_sel_pin, .neg_sel_dac, .conv_enable);

//--- sim/comparator_input_select_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module comparator_input_select_bench;
    import cmpsel_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, dac_division, resp;
    logic cmp_pos_pin_raw, cmp_neg_pin_raw, cmp_pos_buf_enable, cmp_neg_buf_enable;
    logic pos_sel_pin, neg_sel_pin, neg_sel_dac, conv_enable, mux;
    logic [10:0] pos_sel_chan;
    int mismatches = 0, checks = 0, cycles = 0;
    cmpsel_top #(.NUM_CHAN(11)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_pos_pin_raw,
        .cmp_neg_pin_raw, .cmp_pos_buf_enable, .cmp_neg_buf_enable, .pos_sel_pin,
        .pos_sel_chan, .neg_sel_pin, .neg_sel_dac, .dac_division, .conv_enable);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ****************************************************************
    // closing report, timeout and bus tasks
    // ****************************************************************
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    // the whole run needs about 1300 cycles; the ceiling leaves ample margin
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            report_and_stop();
        end
    end
    // address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask : wr
    // rready rises at the edge the address is taken, so the answer is accepted at the first edge it is valid
    task automatic rdw(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : rdw
    task automatic check_reset();
        `CHK("pos_sel_pin", 1'b1, pos_sel_pin)
        `CHK("pos_sel_chan", 11'h0, pos_sel_chan)
        `CHK("neg_sel_pin", 1'b1, neg_sel_pin)
        `CHK("neg_sel_dac", 1'b0, neg_sel_dac)
        `CHK("buf_enable", 2'h3, {cmp_pos_buf_enable, cmp_neg_buf_enable})
        `CHK("dac_division", 2'h0, dac_division)
        `CHK("conv_enable", 1'b0, conv_enable)
        `CHK("bus_idle", 5'h1c, {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid,
            s_axi_rvalid})
    endtask : check_reset
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {cmp_pos_pin_raw, cmp_neg_pin_raw} = 2'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check_reset();
        // rows: channel codes 0 to 15, mux enable and converter enable in every mix
        for (int i = 0; i < 64; i++) begin
            wr(CMPSEL_ADDR_MUX, 8'(i % 16)); // codes above 10 only probe the fallback
            wr(CMPSEL_ADDR_CTRL_B, {1'b0, i[4], 6'h0});
            wr(CMPSEL_ADDR_CTRL_A, {i[5], 7'h0});
            mux = i[4] && !i[5];
            `CHK("pos_sel_pin", !mux, pos_sel_pin)
            `CHK("pos_sel_chan", (mux && i % 16 <= 10) ? 11'(1 << (i % 16)) : 11'h0,
                pos_sel_chan)
            `CHK("conv_enable", i[5], conv_enable)
            rdw(CMPSEL_ADDR_STATUS);
            `CHK("chan_status", {mux && i % 16 <= 10, mux}, rd[3:2])
        end
        // rows: reference select, division and internal reference select
        for (int i = 0; i < 32; i++) begin
            wr(CMPSEL_ADDR_MUX, {i[1:0], 6'h0}); // reference select set first
            wr(CMPSEL_ADDR_CTRL_B, {2'h0, i[3:2], 4'h0});
            wr(CMPSEL_ADDR_CSR, {1'b0, i[4], 6'h0});
            `CHK("neg_sel_pin", !i[4], neg_sel_pin)
            `CHK("neg_sel_dac", i[4] && i[1:0] == 2'h3, neg_sel_dac)
            `CHK("dac_division", i[3:2], dac_division)
            rdw(CMPSEL_ADDR_STATUS);
            `CHK("neg_src", !i[4] ? 2'h0 : (i[1:0] == 2'h3 ? 2'h1 : 2'h2), rd[7:6])
            `CHK("division", i[3:2], rd[5:4])
        end
        // rows: pin levels against the two disable bits
        for (int i = 0; i < 16; i++) begin
            cmp_pos_pin_raw <= i[0];
            cmp_neg_pin_raw <= i[1];
            wr(CMPSEL_ADDR_PIN_DIS, {i[2], i[3], 6'h0});
            `CHK("buf_enable", {!i[2], !i[3]}, {cmp_pos_buf_enable, cmp_neg_buf_enable})
            rdw(CMPSEL_ADDR_PIN);
            `CHK("pin_view", {i[0] && !i[2], i[1] && !i[3]}, rd[1:0])
        end
        // reserved bits read zero
        wr(CMPSEL_ADDR_MUX, 8'hff);
        rdw(CMPSEL_ADDR_MUX);
        `CHK("mux_reg", 32'hdf, rd)
        wr(CMPSEL_ADDR_CTRL_B, 8'hff);
        rdw(CMPSEL_ADDR_CTRL_B);
        `CHK("ctrl_b_reg", 32'h77, rd)
        // a write with no byte strobe must leave the converter off
        wr(CMPSEL_ADDR_CTRL_A, 8'h00);
        wr(CMPSEL_ADDR_CTRL_A, 8'h80, 4'h0);
        `CHK("conv_enable", 1'b0, conv_enable)
        `CHK("strobe_resp", 2'h0, resp)
        wr(CMPSEL_ADDR_STATUS, 8'hff);
        `CHK("ro_resp", 2'h0, resp)
        wr(8'h1c, 8'hff);
        `CHK("unmapped_wr", 2'h2, resp)
        rdw(8'h1c);
        `CHK("unmapped_rd", {2'h2, 32'h0}, {resp, rd})
        // reset in mid-run with channel 5, the divided reference and both disables set
        wr(CMPSEL_ADDR_MUX, 8'hc5);
        `CHK("pre_reset_chan", 11'h020, pos_sel_chan)
        `CHK("pre_reset_dac", 3'h7, {neg_sel_dac, dac_division})
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check_reset();
        report_and_stop();
    end
endmodule : comparator_input_select_bench
